// ### hdl/amp_ctrl_regs.svh
// register indices, field positions, reset values and timing counts of the amplifier control block
// assumes a 100 MHz core clock and register bytes numbered in bus transfer order
`ifndef AMP_CTRL_REGS_SVH
`define AMP_CTRL_REGS_SVH

`define REG_COUNT 3'h6
`define REG_GAIN_R_BTL 3'h0
`define REG_GAIN_L_BTL 3'h1
`define REG_GAIN_R_SE 3'h2
`define REG_GAIN_L_SE 3'h3
`define REG_MASK 3'h4
`define REG_CTRL 3'h5

`define GAIN_RESET 8'h3f
`define MASK_RESET 8'hff
`define CTRL_RESET 8'h00

`define GAIN_LEVEL_MSB 5
`define GAIN_MUTE_LO 6
`define GAIN_MUTE_HI 7
`define MASK_SHUTDOWN_PIN 0
`define MASK_CONFIG_PIN 1
`define MASK_BEEP_AUTO 2
`define MASK_POWERING_UP 7
`define CTRL_SHUTDOWN 0
`define CTRL_HEADPHONE 1
`define CTRL_MUTE 3
`define CTRL_SINGLE_ENDED 5
`define CTRL_GAIN_SE 6
`define CTRL_BEEP_ON 7

`define I2C_BYTE_BITS 4'h8
`define I2C_LAST_TX_BIT 4'h7
`define BEEP_MIN_EDGES 4'h8
`define CORE_CLK_MHZ 100
`define BEEP_LOSS_US 100
`define POWERUP_US 50
`define CDC_GUARD_CYCLES 4'h8
`define ADDR_FIXED_DEFAULT 5'h0d

`endif

// ### hdl/amp_ctrl_pkg.sv
// types shared by the amplifier control block: link state machine and state records
// assumes amp_ctrl_regs.svh for the numeric constants
package amp_ctrl_pkg;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_RX,
    LINK_ACK,
    LINK_TX,
    LINK_RACK,
    LINK_TXLOAD
  } link_state_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] adr_s1;
    logic [1:0] adr_s2;
    link_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [2:0] byte_idx;
    logic rw;
    logic addr_phase;
    logic sda_oe;
    logic [47:0] wbuf;
    logic wr_valid;
  } link_reg_t;

  typedef struct packed {
    logic [2:0] beep_sync;
    logic [1:0] shdn_sync;
    logic [1:0] cfg_sync;
    logic [3:0] edge_cnt;
    logic [15:0] gap_cnt;
    logic beep_det;
    logic [15:0] pu_cnt;
    logic powering_up;
    logic [5:0][7:0] regs;
    logic [47:0] sent;
    logic send;
    logic beep_mode;
    logic shutdown;
    logic bridged;
    logic neg_amp_en;
    logic line_sel;
    logic hp_sel;
    logic mute;
    logic [5:0] gain_left;
    logic [5:0] gain_right;
  } core_reg_t;

endpackage : amp_ctrl_pkg

// ### hdl/i2c_xfer_if.sv
// carries register images between the serial link logic and the core logic
// link_rst_n, wr_* belong to the link clock; rd_data arrives already in the link clock
`timescale 1ns/1ps
interface i2c_xfer_if;
  logic link_rst_n;
  logic wr_valid;
  logic [47:0] wr_data;
  logic [47:0] rd_data;
  modport link (output link_rst_n, output wr_valid, output wr_data, input rd_data);
  modport core (input link_rst_n, input wr_valid, input wr_data, output rd_data);
endinterface : i2c_xfer_if

// ### hdl/word_cdc.sv
// moves a word from one clock to another with a toggle and a two-stage synchroniser
// assumes the source offers at most one word per guard period; data stays stable meanwhile
`timescale 1ns/1ps
`include "amp_ctrl_regs.svh"
module word_cdc #(
  parameter int W = 48
) (
  input wire logic i_src_clk,
  input wire logic i_src_reset_n,
  input wire logic i_src_valid,
  output logic o_src_ready,
  input wire logic [W-1:0] i_src_data,
  input wire logic i_dst_clk,
  input wire logic i_dst_reset_n,
  output logic o_dst_valid,
  output logic [W-1:0] o_dst_data
);
  typedef struct packed {
    logic tog;
    logic [3:0] guard;
    logic [W-1:0] data;
  } src_reg_t;
  typedef struct packed {
    logic [2:0] sync;
    logic valid;
    logic [W-1:0] data;
  } dst_reg_t;

  src_reg_t src_reg, src_next;
  dst_reg_t dst_reg, dst_next;

  // guard keeps the held word still until the far side has surely taken it
  assign o_src_ready = (src_reg.guard == 4'h0);

  always_comb begin
    src_next = src_reg;
    if (!i_src_reset_n) begin
      src_next.tog = 1'b0;
      src_next.guard = 4'h0;
      src_next.data = '0;
    end else if (i_src_valid && o_src_ready) begin
      src_next.tog = ~src_reg.tog;
      src_next.guard = `CDC_GUARD_CYCLES;
      src_next.data = i_src_data;
    end else if (src_reg.guard != 4'h0) begin
      src_next.guard = src_reg.guard - 4'h1;
    end
  end

  always_ff @(posedge i_src_clk) begin
    src_reg <= src_next;
  end

  // data is not cleared by reset so a word sent while this side is still in reset survives
  always_comb begin
    dst_next = dst_reg;
    dst_next.sync = {dst_reg.sync[1:0], src_reg.tog};
    dst_next.valid = i_dst_reset_n && (dst_reg.sync[1] ^ dst_reg.sync[2]);
    if (dst_reg.sync[1] ^ dst_reg.sync[2]) begin
      dst_next.data = src_reg.data;
    end
  end

  always_ff @(posedge i_dst_clk) begin
    dst_reg <= dst_next;
  end

  assign o_dst_valid = dst_reg.valid;
  assign o_dst_data = dst_reg.data;
endmodule : word_cdc

// ### hdl/i2c_slave_link.sv
// serial slave on the link clock: oversamples the bus, frames bytes, acknowledges, sends read data
// assumes the link clock is several times faster than the bus clock
`timescale 1ns/1ps
`include "amp_ctrl_regs.svh"
module i2c_slave_link #(
  parameter logic [4:0] ADDR_FIXED = `ADDR_FIXED_DEFAULT
) (
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_sel,
  output logic o_sda_oe,
  i2c_xfer_if.link xfer
);
  amp_ctrl_pkg::link_reg_t r_reg, r_next;
  logic scl_rise, scl_fall, start_seen, stop_seen, sda_now;
  logic [7:0] rd_byte;

  assign sda_now = r_reg.sda_sync[1];
  assign scl_rise = r_reg.scl_sync[1] & ~r_reg.scl_sync[2];
  assign scl_fall = ~r_reg.scl_sync[1] & r_reg.scl_sync[2];
  assign start_seen = r_reg.scl_sync[1] & r_reg.scl_sync[2] & r_reg.sda_sync[2] & ~sda_now;
  assign stop_seen = r_reg.scl_sync[1] & r_reg.scl_sync[2] & ~r_reg.sda_sync[2] & sda_now;
  // bytes past the sixth read as all ones, leaving the line released
  // byte index is already final in the states that load, so the register value avoids a loop
  assign rd_byte = (r_reg.byte_idx < `REG_COUNT) ? xfer.rd_data[{r_reg.byte_idx, 3'h0} +: 8] : 8'hff;

  always_comb begin
    r_next = r_reg;
    r_next.rst_sync = {r_reg.rst_sync[0], i_reset_n};
    r_next.scl_sync = {r_reg.scl_sync[1:0], i_scl};
    r_next.sda_sync = {r_reg.sda_sync[1:0], i_sda};
    r_next.adr_s1 = i_addr_sel;
    r_next.adr_s2 = r_reg.adr_s1;
    r_next.wr_valid = 1'b0;
    if (!r_reg.rst_sync[1]) begin
      r_next.state = amp_ctrl_pkg::LINK_IDLE;
      r_next.bitcnt = 4'h0;
      r_next.shreg = 8'h00;
      r_next.byte_idx = 3'h0;
      r_next.rw = 1'b0;
      r_next.addr_phase = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.wbuf = '0;
    end else if (start_seen) begin
      r_next.state = amp_ctrl_pkg::LINK_RX;
      r_next.addr_phase = 1'b1;
      r_next.bitcnt = 4'h0;
      r_next.byte_idx = 3'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_seen) begin
      r_next.state = amp_ctrl_pkg::LINK_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      unique case (r_reg.state)
        amp_ctrl_pkg::LINK_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        amp_ctrl_pkg::LINK_RX: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], sda_now};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == `I2C_BYTE_BITS) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.addr_phase) begin
              r_next.addr_phase = 1'b0;
              if (r_reg.shreg[7:1] == {ADDR_FIXED, r_reg.adr_s2}) begin
                r_next.rw = r_reg.shreg[0];
                r_next.sda_oe = 1'b1;
                r_next.state = amp_ctrl_pkg::LINK_ACK;
              end else begin
                r_next.state = amp_ctrl_pkg::LINK_IDLE;
              end
            end else begin
              if (r_reg.byte_idx < `REG_COUNT) begin
                r_next.wbuf[{r_reg.byte_idx, 3'h0} +: 8] = r_reg.shreg;
              end
              // only a complete six-byte image is committed
              r_next.wr_valid = (r_reg.byte_idx == `REG_COUNT - 3'h1);
              if (r_reg.byte_idx != 3'h7) begin
                r_next.byte_idx = r_reg.byte_idx + 3'h1;
              end
              r_next.sda_oe = 1'b1;
              r_next.state = amp_ctrl_pkg::LINK_ACK;
            end
          end
        end
        amp_ctrl_pkg::LINK_ACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            if (r_reg.rw) begin
              r_next.shreg = rd_byte;
              r_next.sda_oe = ~rd_byte[7];
              r_next.state = amp_ctrl_pkg::LINK_TX;
            end else begin
              r_next.state = amp_ctrl_pkg::LINK_RX;
            end
          end
        end
        amp_ctrl_pkg::LINK_TX: begin
          if (scl_fall) begin
            if (r_reg.bitcnt == `I2C_LAST_TX_BIT) begin
              r_next.sda_oe = 1'b0;
              r_next.bitcnt = 4'h0;
              r_next.state = amp_ctrl_pkg::LINK_RACK;
            end else begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b1};
              r_next.sda_oe = ~r_reg.shreg[6];
              r_next.bitcnt = r_reg.bitcnt + 4'h1;
            end
          end
        end
        amp_ctrl_pkg::LINK_RACK: begin
          if (scl_rise) begin
            if (sda_now) begin
              r_next.state = amp_ctrl_pkg::LINK_IDLE;
            end else begin
              if (r_reg.byte_idx != 3'h7) begin
                r_next.byte_idx = r_reg.byte_idx + 3'h1;
              end
              r_next.state = amp_ctrl_pkg::LINK_TXLOAD;
            end
          end
        end
        amp_ctrl_pkg::LINK_TXLOAD: begin
          if (scl_fall) begin
            r_next.shreg = rd_byte;
            r_next.sda_oe = ~rd_byte[7];
            r_next.state = amp_ctrl_pkg::LINK_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk) begin
    r_reg <= r_next;
  end

  assign o_sda_oe = r_reg.sda_oe;
  assign xfer.link_rst_n = r_reg.rst_sync[1];
  assign xfer.wr_valid = r_reg.wr_valid;
  assign xfer.wr_data = r_reg.wbuf;
endmodule : i2c_slave_link

// ### hdl/amp_mode_control.sv
// top of the amplifier control logic: register image, beep detection, output configuration, shutdown
// assumes the bus pins and mode pins are asynchronous; the link clock is free-running
//
// How it works
// - high configuration select disables negative-side amplifiers, positives alone drive headphones
// - active beep deselects line and headphone inputs, drives both channels bridged
// - beep mode uses the fixed 0.3 V/V gain, ignoring gain registers
// - leaving beep mode restores prior mode and volume settings
// - beep while shut down wakes the device, then shutdown resumes after beep
// - auto-detect enters beep after eight rising edges, leaves when signal vanishes
// - beep defaults to auto-detect; the serial interface can force manual selection
// - manual beep selects beep input, drops line and headphone inputs always
// - low shutdown pin mutes outputs and enters low-current state; high runs
// - shutdown pin can be disabled, shutdown then taken from a register bit
// - start is data falling with clock high; stop is data rising with clock high
// - transaction is start, address cycle, any data cycles, then stop
// - each cycle is eight data bits plus one acknowledge bit from receiver
// - on address match the device pulls data low in the ninth clock
// - in writes every byte after the address is acknowledged low for one clock
// - in reads the device sends bytes after its address acknowledge; master acknowledges
// - master ends read with no-acknowledge then stop; device stops sending
// - writes carry all six register bytes; reads return six bytes
// - address is five fixed bits, two select pins, then the read/write flag
// - set mask bit hands a mode to its pin; cleared bit gives register control (beep auto-detection stays live with its bit cleared)
// - low configuration select picks line input and bridged gains; high headphone and single-ended
`timescale 1ns/1ps
`include "amp_ctrl_regs.svh"
module amp_mode_control #(
  parameter logic [4:0] ADDR_FIXED = `ADDR_FIXED_DEFAULT,
  parameter int unsigned BEEP_LOSS_CYCLES = `BEEP_LOSS_US * `CORE_CLK_MHZ,
  parameter int unsigned POWERUP_CYCLES = `POWERUP_US * `CORE_CLK_MHZ
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_address_select_high,
  input wire logic i_address_select_low,
  input wire logic i_output_config_select,
  input wire logic i_shutdown_n,
  input wire logic i_system_beep_input,
  output logic o_beep_mode,
  output logic o_fixed_beep_gain,
  output logic o_line_audio_select,
  output logic o_headphone_audio_select,
  output logic o_bridged_output_mode,
  output logic o_neg_amp_enable,
  output logic o_shutdown,
  output logic o_mute,
  output logic [5:0] o_gain_left,
  output logic [5:0] o_gain_right,
  output logic o_powering_up
);
  i2c_xfer_if xfer ();

  amp_ctrl_pkg::core_reg_t r_reg, r_next;
  logic wr_valid_core;
  logic [47:0] wr_data_core;
  logic rd_ready;
  logic [7:0] mask_bits, ctrl_bits, gain_l_sel, gain_r_sel;
  logic shutdown_req, cfg_pin, single_ended, headphone, gain_se, beep_manual, beep_rise, beep_now;
  logic [47:0] snapshot;

  i2c_slave_link #(
    .ADDR_FIXED(ADDR_FIXED)
  ) u_link (
    .i_link_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_addr_sel({i_address_select_high, i_address_select_low}),
    .o_sda_oe(o_sda_oe),
    .xfer(xfer.link)
  );

  word_cdc #(
    .W(48)
  ) u_wr_cdc (
    .i_src_clk(i_link_clk),
    .i_src_reset_n(xfer.link_rst_n),
    .i_src_valid(xfer.wr_valid),
    .o_src_ready(),
    .i_src_data(xfer.wr_data),
    .i_dst_clk(i_core_clk),
    .i_dst_reset_n(i_reset_n),
    .o_dst_valid(wr_valid_core),
    .o_dst_data(wr_data_core)
  );

  word_cdc #(
    .W(48)
  ) u_rd_cdc (
    .i_src_clk(i_core_clk),
    .i_src_reset_n(i_reset_n),
    .i_src_valid(r_reg.send),
    .o_src_ready(rd_ready),
    .i_src_data(r_reg.sent),
    .i_dst_clk(i_link_clk),
    .i_dst_reset_n(xfer.link_rst_n),
    .o_dst_valid(),
    .o_dst_data(xfer.rd_data)
  );

  // open-drain: the driven level is always low
  assign o_sda_out = 1'b0;

  assign mask_bits = r_reg.regs[`REG_MASK];
  assign ctrl_bits = r_reg.regs[`REG_CTRL];
  assign cfg_pin = r_reg.cfg_sync[1];
  assign beep_rise = r_reg.beep_sync[1] & ~r_reg.beep_sync[2];

  // pin or register per mode function
  assign shutdown_req = mask_bits[`MASK_SHUTDOWN_PIN] ? ~r_reg.shdn_sync[1] : ctrl_bits[`CTRL_SHUTDOWN];
  assign single_ended = mask_bits[`MASK_CONFIG_PIN] ? cfg_pin : ctrl_bits[`CTRL_SINGLE_ENDED];
  assign headphone = mask_bits[`MASK_CONFIG_PIN] ? cfg_pin : ctrl_bits[`CTRL_HEADPHONE];
  assign gain_se = mask_bits[`MASK_CONFIG_PIN] ? cfg_pin : ctrl_bits[`CTRL_GAIN_SE];
  assign beep_manual = ~mask_bits[`MASK_BEEP_AUTO] & ctrl_bits[`CTRL_BEEP_ON];
  // auto detection stays live even while manual forcing is on
  assign beep_now = beep_manual | r_reg.beep_det;

  assign gain_l_sel = gain_se ? r_reg.regs[`REG_GAIN_L_SE] : r_reg.regs[`REG_GAIN_L_BTL];
  assign gain_r_sel = gain_se ? r_reg.regs[`REG_GAIN_R_SE] : r_reg.regs[`REG_GAIN_R_BTL];

  // read image: the power-up flag replaces the stored top mask bit
  always_comb begin
    snapshot = r_reg.regs;
    snapshot[{`REG_MASK, 3'h0} + 6'(`MASK_POWERING_UP)] = r_reg.powering_up;
  end

  always_comb begin
    r_next = r_reg;
    r_next.beep_sync = {r_reg.beep_sync[1:0], i_system_beep_input};
    r_next.shdn_sync = {r_reg.shdn_sync[0], i_shutdown_n};
    r_next.cfg_sync = {r_reg.cfg_sync[0], i_output_config_select};
    r_next.send = 1'b0;
    if (!i_reset_n) begin
      r_next.regs[`REG_GAIN_R_BTL] = `GAIN_RESET;
      r_next.regs[`REG_GAIN_L_BTL] = `GAIN_RESET;
      r_next.regs[`REG_GAIN_R_SE] = `GAIN_RESET;
      r_next.regs[`REG_GAIN_L_SE] = `GAIN_RESET;
      r_next.regs[`REG_MASK] = `MASK_RESET;
      r_next.regs[`REG_CTRL] = `CTRL_RESET;
      r_next.edge_cnt = 4'h0;
      r_next.gap_cnt = 16'h0000;
      r_next.beep_det = 1'b0;
      r_next.pu_cnt = 16'h0000;
      r_next.powering_up = 1'b1;
      r_next.sent = '0;
      r_next.beep_mode = 1'b0;
      r_next.shutdown = 1'b0;
      r_next.bridged = 1'b1;
      r_next.neg_amp_en = 1'b0;
      r_next.line_sel = 1'b0;
      r_next.hp_sel = 1'b0;
      r_next.mute = 1'b1;
      r_next.gain_left = 6'h3f;
      r_next.gain_right = 6'h3f;
    end else begin
      if (r_reg.powering_up) begin
        if (r_reg.pu_cnt == 16'(POWERUP_CYCLES - 1)) begin
          r_next.powering_up = 1'b0;
        end else begin
          r_next.pu_cnt = r_reg.pu_cnt + 16'h0001;
        end
      end

      // full six-byte image only; gain registers stay untouched by beep so they come back intact
      if (wr_valid_core) begin
        r_next.regs = wr_data_core;
      end

      // edge counter restarts whenever edges stop for the loss window
      if (beep_rise) begin
        r_next.gap_cnt = 16'h0000;
        if (!r_reg.beep_det) begin
          if (r_reg.edge_cnt == `BEEP_MIN_EDGES - 4'h1) begin
            r_next.beep_det = 1'b1;
            r_next.edge_cnt = 4'h0;
          end else begin
            r_next.edge_cnt = r_reg.edge_cnt + 4'h1;
          end
        end
      end else if (r_reg.gap_cnt == 16'(BEEP_LOSS_CYCLES - 1)) begin
        r_next.beep_det = 1'b0;
        r_next.edge_cnt = 4'h0;
      end else begin
        r_next.gap_cnt = r_reg.gap_cnt + 16'h0001;
      end

      r_next.beep_mode = beep_now;
      r_next.shutdown = shutdown_req & ~beep_now;
      r_next.bridged = beep_now | ~single_ended;
      r_next.neg_amp_en = ~(shutdown_req & ~beep_now) & (beep_now | ~single_ended);
      r_next.line_sel = ~beep_now & ~headphone;
      r_next.hp_sel = ~beep_now & headphone;
      // beep ignores register mutes and volume; the fixed gain takes over
      r_next.mute = ~beep_now & (shutdown_req | ctrl_bits[`CTRL_MUTE] | gain_l_sel[`GAIN_MUTE_LO] |
                    gain_l_sel[`GAIN_MUTE_HI] | gain_r_sel[`GAIN_MUTE_LO] | gain_r_sel[`GAIN_MUTE_HI]);
      r_next.gain_left = gain_l_sel[`GAIN_LEVEL_MSB:0];
      r_next.gain_right = gain_r_sel[`GAIN_LEVEL_MSB:0];

      if (rd_ready && snapshot != r_reg.sent) begin
        r_next.sent = snapshot;
        r_next.send = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    r_reg <= r_next;
  end

  assign o_beep_mode = r_reg.beep_mode;
  assign o_fixed_beep_gain = r_reg.beep_mode;
  assign o_line_audio_select = r_reg.line_sel;
  assign o_headphone_audio_select = r_reg.hp_sel;
  assign o_bridged_output_mode = r_reg.bridged;
  assign o_neg_amp_enable = r_reg.neg_amp_en;
  assign o_shutdown = r_reg.shutdown;
  assign o_mute = r_reg.mute;
  assign o_gain_left = r_reg.gain_left;
  assign o_gain_right = r_reg.gain_right;
  assign o_powering_up = r_reg.powering_up;
endmodule : amp_mode_control

// ### test/i2c_master_model.sv
// bus master model: drives the serial clock and pulls data low, samples the resolved line
// assumes an external pull-up resolves the data wire; bus clock well below a quarter of the link clock
`timescale 1ns/1ps
module i2c_master_model (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  localparam time HALF = 200ns;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task start(); // data falls while clock high
    #HALF o_sda_low = 1'b1;
    #HALF o_scl = 1'b0;
  endtask : start
  // data only changes mid-low, sampled mid-high
  task bit_x(input logic b, output logic r);
    #(HALF/2) o_sda_low = !b;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) r = i_sda;
    #(HALF/2) o_scl = 1'b0;
  endtask : bit_x
  // 8 bits msb first then the ack slot; writes release data in the slot
  task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack_out); // nack on last read byte
  endtask : xfer
  task stop(); // data rises while clock high
    #(HALF/2) o_sda_low = 1'b1;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) o_sda_low = 1'b0;
    #HALF;
  endtask : stop
endmodule : i2c_master_model

// ### test/amp_mode_control_chk.sv
// output relations of the amplifier control block in the core clock domain
// assumes binding onto amp_mode_control with its port names
`timescale 1ns/1ps
module amp_mode_control_chk (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_beep_mode,
  input wire logic o_fixed_beep_gain,
  input wire logic o_line_audio_select,
  input wire logic o_headphone_audio_select,
  input wire logic o_bridged_output_mode,
  input wire logic o_neg_amp_enable,
  input wire logic o_shutdown,
  input wire logic o_mute
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_beep_sel;
    o_beep_mode |-> !o_line_audio_select && !o_headphone_audio_select && o_bridged_output_mode;
  endproperty
  property p_beep_gain; o_fixed_beep_gain == o_beep_mode; endproperty
  property p_beep_wake; o_beep_mode |-> !o_shutdown; endproperty
  property p_beep_unmute; o_beep_mode |-> !o_mute; endproperty
  property p_neg_amp; o_neg_amp_enable |-> o_bridged_output_mode && !o_shutdown; endproperty
  property p_shdn_mute; o_shutdown |-> o_mute; endproperty
  property p_sda_level; o_sda_out == 1'b0; endproperty
  property p_oe_hold; $rose(o_sda_oe) |-> o_sda_oe[*8]; endproperty
  property p_input_excl;
    $past(i_reset_n) && !o_beep_mode |-> o_line_audio_select != o_headphone_audio_select;
  endproperty
  a_beep_sel: assert property (p_beep_sel) else $error("beep input selection wrong");
  a_beep_gain: assert property (p_beep_gain) else $error("fixed gain flag wrong");
  a_beep_wake: assert property (p_beep_wake) else $error("shutdown during beep");
  a_beep_unmute: assert property (p_beep_unmute) else $error("mute during beep");
  a_neg_amp: assert property (p_neg_amp) else $error("negative amps on wrongly");
  a_shdn_mute: assert property (p_shdn_mute) else $error("shutdown not muted");
  a_sda_level: assert property (p_sda_level) else $error("data driven high");
  a_oe_hold: assert property (p_oe_hold) else $error("ack pulse too short");
  a_input_excl: assert property (p_input_excl) else $error("input select wrong");
  c_beep: cover property ($rose(o_beep_mode));
  c_ack: cover property ($rose(o_sda_oe));
  c_shdn: cover property ($rose(o_shutdown));
endmodule : amp_mode_control_chk
bind amp_mode_control amp_mode_control_chk u_chk (.*);

// ### test/amp_mode_control_bench.sv
// self-checking bench: mode pins, beep detection, serial register writes and reads
// assumes the bus master model and a pull-up on the data wire
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module amp_mode_control_bench;
  logic i_core_clk = 1'b0, i_link_clk = 1'b0, i_reset_n = 1'b0;
  logic cfg = 1'b0, shdn_n = 1'b1, beep = 1'b0;
  logic scl, sda_low, sda_oe, bm, fg, ls, hs, br, ng, sd, mt, pu;
  logic [5:0] gl, gr;
  wire sda = !(sda_oe || sda_low);
  int failures = 0, n_checks = 0;
  localparam logic [6:0] ADR = {5'h0d, 2'b10};
  initial forever #5 i_core_clk = ~i_core_clk;
  initial begin
    #3.3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  amp_mode_control #(.BEEP_LOSS_CYCLES(200), .POWERUP_CYCLES(20)) u_dut (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda), .o_sda_out(),
    .o_sda_oe(sda_oe), .i_address_select_high(1'b1), .i_address_select_low(1'b0),
    .i_output_config_select(cfg), .i_shutdown_n(shdn_n), .i_system_beep_input(beep),
    .o_beep_mode(bm), .o_fixed_beep_gain(fg), .o_line_audio_select(ls), .o_headphone_audio_select(hs),
    .o_bridged_output_mode(br), .o_neg_amp_enable(ng), .o_shutdown(sd), .o_mute(mt),
    .o_gain_left(gl), .o_gain_right(gr), .o_powering_up(pu));
  i2c_master_model u_master (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  task step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  task pulses(input int n);
    repeat (n) begin
      beep = 1'b1;
      step(4);
      beep = 1'b0;
      step(4);
    end
  endtask : pulses
  task wr_regs(input logic [6:0] adr, input logic [47:0] v, input logic ack_exp);
    logic [7:0] q;
    logic a;
    u_master.start();
    u_master.xfer({adr, 1'b0}, 1'b1, q, a);
    `CHK(a, ack_exp)
    if (ack_exp == 1'b0) for (int k = 0; k < 6; k++) begin
      u_master.xfer(v[47-8*k -: 8], 1'b1, q, a);
      `CHK(a, 1'b0)
    end
    u_master.stop();
    step(100);
  endtask : wr_regs
  task rd_regs(input logic [47:0] v);
    logic [7:0] q;
    logic a;
    u_master.start();
    u_master.xfer({ADR, 1'b1}, 1'b1, q, a);
    `CHK(a, 1'b0)
    for (int k = 0; k < 6; k++) begin
      u_master.xfer(8'hff, k == 5, q, a);
      `CHK(q, v[47-8*k -: 8])
    end
    u_master.stop();
    `CHK(sda_oe, 1'b0)
  endtask : rd_regs
  task conclude();
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #500us;
    failures++;
    conclude();
  end
  initial begin
    step(4);
    i_reset_n = 1'b1;
    step(5);
    `CHK(pu, 1'b1)
    step(25);
    `CHK({gr, gl, bm, pu}, {6'h3f, 6'h3f, 2'b00})
    cfg = 1'b1;
    step(5);
    `CHK({br, ng, ls, hs}, 4'b0001)
    cfg = 1'b0;
    step(5);
    `CHK({br, ng, ls, hs}, 4'b1110)
    shdn_n = 1'b0;
    step(5);
    `CHK({sd, mt, ng}, 3'b110)
    pulses(7);
    `CHK(bm, 1'b0)
    pulses(1);
    `CHK({bm, fg, sd, ls, hs, br, mt}, 7'b1100010)
    step(220);
    `CHK({bm, sd}, 2'b01)
    shdn_n = 1'b1;
    step(5);
    wr_regs(ADR, 48'h050a11220002, 1'b0);
    `CHK({gr, gl, hs, ls}, {6'h05, 6'h0a, 2'b10})
    shdn_n = 1'b0;
    step(5);
    `CHK(sd, 1'b0)
    shdn_n = 1'b1;
    rd_regs(48'h050a11220002);
    wr_regs(ADR, 48'h050a112200c1, 1'b0);
    `CHK({bm, sd, ls, hs}, 4'b1000)
    wr_regs(ADR, 48'h050a11220041, 1'b0);
    `CHK({bm, sd, mt, gl}, {3'b011, 6'h22})
    wr_regs({5'h0d, 2'b01}, 48'h0, 1'b1);
    conclude();
  end
endmodule : amp_mode_control_bench
